// ---- logic/sfl_pkg.sv ----
// Shared constants and types of the serial flash command sequencer.
// Assumes a single clock domain; pins are synchronised in the top module.
package sfl_pkg;

    // ========================================
    // Array geometry
    localparam int unsigned ADDR_W      = 19;
    localparam int unsigned PAGE_W      = 8;
    localparam int unsigned SECTOR_W    = 12;
    localparam int unsigned PAGE_BYTES  = 256;
    localparam int unsigned ARRAY_BYTES = 524288;

    // ========================================
    // Lower bounds of the locked-out top regions
    localparam logic [18:0] PROT_1_64 = 19'h7E000;
    localparam logic [18:0] PROT_1_32 = 19'h7C000;
    localparam logic [18:0] PROT_1_16 = 19'h78000;
    localparam logic [18:0] PROT_1_8  = 19'h70000;
    localparam logic [18:0] PROT_1_4  = 19'h60000;
    localparam logic [18:0] PROT_1_2  = 19'h40000;

    // ========================================
    // Status byte
    localparam logic [7:0] STATUS_BUSY = 8'hFF;
    localparam logic [2:0] LAST_BIT    = 3'h7;

    // ========================================
    // Types
    typedef enum logic [2:0] {
        PH_OPCODE, PH_ADDR, PH_DUMMY, PH_RDATA,
        PH_PDATA, PH_EWAIT, PH_STATUS, PH_IGNORE
    } sfl_phase_type;

    typedef enum logic [1:0] {CMD_READ, CMD_PROG, CMD_ERASE} sfl_cmd_type;

    typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} sfl_op_type;

    typedef struct packed {
        logic sel;
        logic sck;
        logic si;
    } sfl_pins_type;

    typedef struct packed {
        sfl_pins_type  sync1;
        sfl_pins_type  sync2;
        sfl_pins_type  sync3;
        logic [5:0]    prot1;
        logic [5:0]    prot2;
        sfl_phase_type phase;
        sfl_cmd_type   cmd;
        sfl_op_type    op;
        logic [7:0]    shift;
        logic [2:0]    bitcnt;
        logic [1:0]    bytecnt;
        logic [23:0]   addr;
        logic [7:0]    dout;
        logic [2:0]    obit;
        logic [7:0]    pidx;
        logic [255:0]  loaded;
        logic [11:0]   walk;
        logic          wel;
        logic          busy;
        logic          so;
        logic          so_oe;
    } sfl_state_type;

endpackage

// ---- logic/sfl_flash.sv ----
// Serial flash device: command decode, fast read, page program, sector erase.
// Assumes SPI mode 0 pins from a host; all pins are asynchronous to mclk_i.
//
// Operation
// (R1) Fast read: opcode, address, dummy byte; output stays off through dummy.
// (R2) Host clocks fast read no faster than the standard read maximum.
// (R3) Input data is ignored while read data is shifted out.
// (R4) Address counter advances each byte; next byte follows with no gap.
// (R5) Sequential read wraps from the top address to zero.
// (R6) Output bytes go most significant bit first.
// (R7) Chip select rising ends a read at any point; standby follows.
// (R8) Program only clears bits and writes at most one page.
// (R9) Program without write enable is ignored until chip select rises.
// (R10) Program cycle starts only on chip select rising after data bytes.
// (R11) Host raises chip select right after the last bit of a byte.
// (R12) Busy shows as status bit zero during a program cycle.
// (R13) While busy only the status read is accepted.
// (R14) Program address wraps inside the page; extra bytes overwrite.
// (R15) Unwritten bytes of the page stay unchanged.
// (R16) Write enable clears when a program cycle ends.
// (R17) Array holds 524288 bytes in 2048 pages of 256.
// (R18) Bytes must be erased before they can be programmed again.
// (R19) Array has 4 KB sectors and 64 KB blocks.
// (R20) Sector erase sets the sector to ones unless locked out.
// (R21) Sector erase ignores the address bits inside the sector.
// (R22) Erase is self-timed, reports busy, and clears write enable.
// (R23) Block-protected regions are never programmed or erased.
// (R24) During a write cycle the status read returns all ones.
// (R25) Only the low nineteen address bits select a byte.
// (R26) Opcodes are configurable parameters.
`timescale 1ns/1ps

module sfl_flash #(
    // Opcode values are arbitrary defaults.
    // (R26) configurable opcodes
    parameter logic [7:0] OPC_FAST_READ = 8'h10,
    parameter logic [7:0] OPC_PROGRAM   = 8'h20,
    parameter logic [7:0] OPC_SECT_ERS  = 8'h30,
    parameter logic [7:0] OPC_WR_ENABLE = 8'h40,
    parameter logic [7:0] OPC_ST_READ   = 8'h50
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       cs_n_i,
    input  wire logic       sck_i,
    input  wire logic       si_i,
    input  wire logic [4:0] block_protect_i,
    input  wire logic       hw_protect_enable_bit_i,
    output logic            so_o,
    output logic            so_oe_o,
    output logic            busy_o,
    output logic            write_enable_o
);

    // ========================================
    // State and storage
    sfl_pkg::sfl_state_type s_ff;
    sfl_pkg::sfl_state_type nxt_s;

    // (R17) full byte array
    logic [7:0] mem_ff [0:sfl_pkg::ARRAY_BYTES-1];
    logic [7:0] page_buf_ff [0:sfl_pkg::PAGE_BYTES-1];

    logic        mem_we;
    logic [18:0] mem_waddr;
    logic [7:0]  mem_wdata;
    logic        buf_we;
    logic [7:0]  buf_waddr;
    logic [7:0]  buf_wdata;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_rise;
    logic [7:0]  rx_byte;
    logic [7:0]  rd_word;
    logic [18:0] walk_addr;
    logic [7:0]  walk_old;
    logic [7:0]  status_byte;
    logic        addr_locked;

    // ========================================
    // Lock-out decode of the top region.
    // (R23) protected region check
    function automatic logic is_locked(input logic [18:0] a, input logic [4:0] bp);
        logic r;
        r = 1'b0;
        if (bp[2]) begin
            r = 1'b1;
        end else begin
            case (bp[1:0])
                2'h1: r = (a >= sfl_pkg::PROT_1_8);
                2'h2: r = (a >= sfl_pkg::PROT_1_4);
                2'h3: r = (a >= sfl_pkg::PROT_1_2);
                default: begin
                    case (bp[4:3])
                        2'h1: r = (a >= sfl_pkg::PROT_1_64);
                        2'h2: r = (a >= sfl_pkg::PROT_1_32);
                        2'h3: r = (a >= sfl_pkg::PROT_1_16);
                        default: r = 1'b0;
                    endcase
                end
            endcase
        end
        return r;
    endfunction

    // ========================================
    // Edges seen between the second and third synchroniser stages.
    assign sck_rise = s_ff.sync2.sck & ~s_ff.sync3.sck;
    assign sck_fall = ~s_ff.sync2.sck & s_ff.sync3.sck;
    assign cs_rise  = ~s_ff.sync2.sel & s_ff.sync3.sel;
    assign rx_byte  = {s_ff.shift[6:0], s_ff.sync2.si};

    // (R25) low nineteen bits address the array
    assign rd_word     = mem_ff[s_ff.addr[18:0]];
    assign addr_locked = is_locked(s_ff.addr[18:0], s_ff.prot2[4:0]);

    // Walk address of the running internal cycle.
    // (R19) uniform 4 KB sectors
    // (R21) sector base ignores low bits
    assign walk_addr = (s_ff.op == sfl_pkg::OP_ERASE) ?
                       {s_ff.addr[18:12], s_ff.walk} :
                       {s_ff.addr[18:8], s_ff.walk[7:0]};
    assign walk_old  = mem_ff[walk_addr];

    // (R24) all ones while busy, else live status
    // (R12) busy in bit zero
    assign status_byte = s_ff.busy ? sfl_pkg::STATUS_BUSY :
                         {s_ff.prot2[5], s_ff.prot2[4:0], s_ff.wel, s_ff.busy};

    // ========================================
    // Next-state logic of the whole sequencer.
    always_comb begin
        nxt_s     = s_ff;
        mem_we    = 1'b0;
        mem_waddr = 19'h00000;
        mem_wdata = 8'h00;
        buf_we    = 1'b0;
        buf_waddr = 8'h00;
        buf_wdata = 8'h00;
        nxt_s.sync1.sel = ~cs_n_i;
        nxt_s.sync1.sck = sck_i;
        nxt_s.sync1.si  = si_i;
        nxt_s.sync2 = s_ff.sync1;
        nxt_s.sync3 = s_ff.sync2;
        nxt_s.prot1 = {hw_protect_enable_bit_i, block_protect_i};
        nxt_s.prot2 = s_ff.prot1;

        if (!s_ff.sync2.sel) begin
            // (R10) launch on chip select rising
            if (cs_rise && s_ff.bitcnt == 3'h0 && !addr_locked) begin
                if (s_ff.phase == sfl_pkg::PH_PDATA && |s_ff.loaded) begin
                    nxt_s.op   = sfl_pkg::OP_PROG;
                    nxt_s.busy = 1'b1;
                    nxt_s.walk = 12'h000;
                end else if (s_ff.phase == sfl_pkg::PH_EWAIT) begin
                    nxt_s.op   = sfl_pkg::OP_ERASE;
                    nxt_s.busy = 1'b1;
                    nxt_s.walk = 12'h000;
                end
            end
            // (R7) deselect returns to standby
            nxt_s.phase   = sfl_pkg::PH_OPCODE;
            nxt_s.bitcnt  = 3'h0;
            nxt_s.bytecnt = 2'h0;
            nxt_s.so_oe   = 1'b0;
        end else if (sck_rise) begin
            nxt_s.shift  = rx_byte;
            nxt_s.bitcnt = s_ff.bitcnt + 3'h1;
            if (s_ff.bitcnt == sfl_pkg::LAST_BIT) begin
                case (s_ff.phase)
                    sfl_pkg::PH_OPCODE: begin
                        nxt_s.phase = sfl_pkg::PH_IGNORE;
                        // (R13) only status read while busy
                        if (rx_byte == OPC_ST_READ) begin
                            nxt_s.phase = sfl_pkg::PH_STATUS;
                            nxt_s.dout  = status_byte;
                            nxt_s.obit  = 3'h0;
                            nxt_s.so_oe = 1'b1;
                        end else if (!s_ff.busy) begin
                            if (rx_byte == OPC_WR_ENABLE) begin
                                nxt_s.wel = 1'b1;
                            end else if (rx_byte == OPC_FAST_READ) begin
                                nxt_s.phase = sfl_pkg::PH_ADDR;
                                nxt_s.cmd   = sfl_pkg::CMD_READ;
                            end else if (rx_byte == OPC_PROGRAM && s_ff.wel) begin
                                // (R9) program needs write enable
                                nxt_s.phase  = sfl_pkg::PH_ADDR;
                                nxt_s.cmd    = sfl_pkg::CMD_PROG;
                                nxt_s.loaded = '0;
                            end else if (rx_byte == OPC_SECT_ERS && s_ff.wel) begin
                                nxt_s.phase = sfl_pkg::PH_ADDR;
                                nxt_s.cmd   = sfl_pkg::CMD_ERASE;
                            end
                        end
                    end
                    sfl_pkg::PH_ADDR: begin
                        nxt_s.addr    = {s_ff.addr[15:0], rx_byte};
                        nxt_s.bytecnt = s_ff.bytecnt + 2'h1;
                        nxt_s.pidx    = rx_byte;
                        if (s_ff.bytecnt == 2'h2) begin
                            case (s_ff.cmd)
                                sfl_pkg::CMD_READ:  nxt_s.phase = sfl_pkg::PH_DUMMY;
                                sfl_pkg::CMD_PROG:  nxt_s.phase = sfl_pkg::PH_PDATA;
                                default:            nxt_s.phase = sfl_pkg::PH_EWAIT;
                            endcase
                        end
                    end
                    sfl_pkg::PH_DUMMY: begin
                        // (R1) output enabled only after dummy byte
                        nxt_s.phase = sfl_pkg::PH_RDATA;
                        nxt_s.dout  = rd_word;
                        nxt_s.addr  = {5'h00, s_ff.addr[18:0] + 19'h00001};
                        nxt_s.obit  = 3'h0;
                        nxt_s.so_oe = 1'b1;
                    end
                    sfl_pkg::PH_PDATA: begin
                        // (R14) index wraps within the page
                        buf_we    = 1'b1;
                        buf_waddr = s_ff.pidx;
                        buf_wdata = rx_byte;
                        nxt_s.loaded[s_ff.pidx] = 1'b1;
                        nxt_s.pidx = s_ff.pidx + 8'h01;
                    end
                    default: begin
                        // (R3) input ignored while reading out
                        nxt_s.phase = s_ff.phase;
                    end
                endcase
            end
        end else if (sck_fall && s_ff.so_oe) begin
            // (R6) most significant bit first
            nxt_s.so   = s_ff.dout[sfl_pkg::LAST_BIT - s_ff.obit];
            nxt_s.obit = s_ff.obit + 3'h1;
            if (s_ff.obit == sfl_pkg::LAST_BIT) begin
                if (s_ff.phase == sfl_pkg::PH_RDATA) begin
                    // (R4) next byte with no gap
                    // (R5) wrap to zero at the top
                    nxt_s.dout = rd_word;
                    nxt_s.addr = {5'h00, s_ff.addr[18:0] + 19'h00001};
                end else begin
                    nxt_s.dout = status_byte;
                end
            end
        end

        // Internal program and erase walks, one byte per cycle.
        case (s_ff.op)
            sfl_pkg::OP_PROG: begin
                // (R8) bits only go from one to zero
                // (R15) untouched bytes keep their data
                mem_we    = s_ff.loaded[s_ff.walk[7:0]];
                // (R18) cleared bits stay cleared
                mem_waddr = walk_addr;
                mem_wdata = walk_old & page_buf_ff[s_ff.walk[7:0]];
                nxt_s.walk = s_ff.walk + 12'h001;
                if (s_ff.walk[7:0] == 8'hFF) begin
                    // (R16) write enable drops at the end
                    nxt_s.op     = sfl_pkg::OP_IDLE;
                    nxt_s.busy   = 1'b0;
                    nxt_s.wel    = 1'b0;
                    nxt_s.loaded = '0;
                end
            end
            sfl_pkg::OP_ERASE: begin
                // (R20) sector set to all ones
                mem_we     = 1'b1;
                mem_waddr  = walk_addr;
                mem_wdata  = 8'hFF;
                nxt_s.walk = s_ff.walk + 12'h001;
                if (s_ff.walk == 12'hFFF) begin
                    // (R22) self-timed end clears write enable
                    nxt_s.op   = sfl_pkg::OP_IDLE;
                    nxt_s.busy = 1'b0;
                    nxt_s.wel  = 1'b0;
                end
            end
            default: begin
                // Idle: the walk start value set at launch must not be overwritten.
                mem_we = 1'b0;
            end
        endcase
    end

    // ========================================
    // State register.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Array and page buffer write ports; contents are not reset.
    always_ff @(posedge mclk_i) begin
        if (mem_we) begin
            mem_ff[mem_waddr] <= mem_wdata;
        end
        if (buf_we) begin
            page_buf_ff[buf_waddr] <= buf_wdata;
        end
    end

    // ========================================
    // Outputs straight from the state register.
    assign so_o           = s_ff.so;
    assign so_oe_o        = s_ff.so_oe;
    assign busy_o         = s_ff.busy;
    assign write_enable_o = s_ff.wel;

endmodule

// ---- tb/sfl_flash_asserts.sv ----
// Port checker of sfl_flash, bound to every instance of it.
// Assumes one clock domain on mclk_i and rst_n_i active low.
`timescale 1ns/1ps
module sfl_flash_chk (
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    input wire logic       cs_n_i,
    input wire logic       sck_i,
    input wire logic       si_i,
    input wire logic [4:0] block_protect_i,
    input wire logic       hw_protect_enable_bit_i,
    input wire logic       so_o,
    input wire logic       so_oe_o,
    input wire logic       busy_o,
    input wire logic       write_enable_o
);
    // ========================================
    // Helper logic
    // Longest busy spell is the 4096-cycle sector erase; the limit leaves some slack.
    localparam logic [12:0] BUSY_LIMIT = 13'h1068;
    logic [12:0] busy_cnt_ff;

    // Counts busy cycles and saturates so that a hang keeps failing.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_cnt_ff <= 13'h0000;
        end else if (busy_o && busy_cnt_ff != 13'h1FFF) begin
            busy_cnt_ff <= busy_cnt_ff + 13'h0001;
        end else if (!busy_o) begin
            busy_cnt_ff <= 13'h0000;
        end
    end

    // ========================================
    // Properties
    // All properties share the system clock and its reset.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    wel_clear_a: assert property ($fell(busy_o) |-> !write_enable_o)
        else $error("Write enable kept after busy.");
    busy_armed_a: assert property ($rose(busy_o) |-> $past(write_enable_o))
        else $error("Busy without write enable.");
    busy_on_cs_a: assert property ($rose(busy_o) |-> cs_n_i && $past(cs_n_i, 2))
        else $error("Busy began inside a frame.");
    busy_hold_a: assert property ($rose(busy_o) |=> busy_o [*8])
        else $error("Busy too short.");
    busy_ends_a: assert property (busy_cnt_ff <= BUSY_LIMIT)
        else $error("Busy never ended.");
    oe_release_a: assert property (cs_n_i [*6] |-> !so_oe_o)
        else $error("Output driven while deselected.");
    oe_start_a: assert property ($rose(so_oe_o) |-> !cs_n_i && $past(sck_i, 2))
        else $error("Output enabled off a clock rise.");
    so_shift_a: assert property (so_oe_o && $past(so_oe_o) && $changed(so_o) |-> !sck_i)
        else $error("Output bit changed while clock high.");
    wel_idle_a: assert property ($rose(write_enable_o) |-> !busy_o)
        else $error("Write enable taken while busy.");

    // Main scenarios reached.
    cover property ($rose(busy_o));
    cover property ($rose(so_oe_o));
    cover property ($rose(write_enable_o));
endmodule

bind sfl_flash sfl_flash_chk sfl_flash_chk_i (.mclk_i, .rst_n_i, .cs_n_i, .sck_i, .si_i,
    .block_protect_i, .hw_protect_enable_bit_i, .so_o, .so_oe_o, .busy_o, .write_enable_o);

// ---- tb/sfl_host.sv ----
// Host model of the serial bus: mode 0 frames on cs_n, sck and si.
// Assumes mclk_i at 125 MHz; one serial bit spans 20 clock cycles.
`timescale 1ns/1ps
module sfl_host (
    input  wire logic mclk_i,
    input  wire logic so_i,
    input  wire logic so_oe_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o,
    output logic      oe_seen_o
);
    localparam int HALF = 10;

    // Idle pins: deselected, clock parked low.
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
        oe_seen_o = 1'b0;
    end

    // Records any output drive within a frame.
    always @(posedge mclk_i) begin
        if (!cs_n_o && so_oe_i) begin
            oe_seen_o <= 1'b1;
        end
    end

    // Selects the device.
    task automatic frame_begin();
        oe_seen_o <= 1'b0;
        cs_n_o <= 1'b0;
        repeat (HALF) @(posedge mclk_i);
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_o <= tx[i];
            repeat (HALF) @(posedge mclk_i);
            sck_o <= 1'b1;
            rx[i] = so_oe_i ? so_i : 1'bz;
            repeat (HALF) @(posedge mclk_i);
            sck_o <= 1'b0;
        end
    endtask

    task automatic frame_end();
        repeat (4) @(posedge mclk_i);
        cs_n_o <= 1'b1;
        si_o <= ~si_o;
        repeat (2 * HALF) @(posedge mclk_i);
    endtask
endmodule

// ---- tb/tb_top.sv ----
// Testbench of sfl_flash: erase, program, fast read and lock-out.
// Assumes the host model sfl_host drives the serial pins.
`timescale 1ns/1ps
module tb_top;
    logic       mclk = 1'b0;
    logic       rst_n;
    logic [4:0] bp;
    logic       hw;
    logic       cs_n, sck, si, so, so_oe, busy, wel, seen;
    logic [7:0] r;
    int         fail_count = 0;
    int         num_checks = 0;
    int         cycles = 0;

    // Clock of 8 ns period.
    always #4 mclk = ~mclk;

    sfl_host sfl_host_i (.mclk_i(mclk), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n),
        .sck_o(sck), .si_o(si), .oe_seen_o(seen));
    sfl_flash sfl_flash_i (.mclk_i(mclk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sck_i(sck),
        .si_i(si), .block_protect_i(bp), .hw_protect_enable_bit_i(hw), .so_o(so),
        .so_oe_o(so_oe), .busy_o(busy), .write_enable_o(wel));

    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic done(input string s);
        $display("Test %s done", s);
    endtask

    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Opens a frame with an opcode and a three byte address.
    task automatic cmd(input logic [7:0] op, input logic [23:0] a);
        sfl_host_i.frame_begin();
        sfl_host_i.xfer(op, r);
        for (int i = 2; i >= 0; i--) begin
            sfl_host_i.xfer(a[8*i +: 8], r);
        end
    endtask

    task automatic write_enable_cmd();
        sfl_host_i.frame_begin();
        sfl_host_i.xfer(8'h40, r);
        sfl_host_i.frame_end();
        check("write enable", {7'h00, wel}, 8'h01);
    endtask

    // Polls the status byte within one frame until the cycle ends.
    task automatic poll(input logic b, input logic [7:0] idle);
        int n = 0;
        sfl_host_i.frame_begin();
        sfl_host_i.xfer(8'h50, r);
        sfl_host_i.xfer(8'h5A, r);
        if (b) check("busy status", r, 8'hFF);
        while (r[0] !== 1'b0 && n < 40) begin
            sfl_host_i.xfer(8'hA5, r);
            n++;
        end
        sfl_host_i.frame_end();
        check("idle status", r, idle);
    endtask

    task automatic erase(input logic [23:0] a, input logic probe);
        write_enable_cmd();
        cmd(8'h30, a);
        sfl_host_i.frame_end();
        if (probe) begin
            cmd(8'h10, a);
            sfl_host_i.xfer(8'h00, r);
            sfl_host_i.xfer(8'h00, r);
            sfl_host_i.frame_end();
            check("read while busy", {7'h00, seen}, 8'h00);
        end
        poll(1'b1, {hw, bp, 2'b00});
    endtask

    task automatic prog(input logic [23:0] a, input logic [31:0] d, input int n);
        write_enable_cmd();
        cmd(8'h20, a);
        for (int i = 0; i < n; i++) begin
            sfl_host_i.xfer(d[31-8*i -: 8], r);
        end
        sfl_host_i.frame_end();
        poll(1'b1, {hw, bp, 2'b00});
    endtask

    // Fast read with a dummy byte; si carries junk meanwhile.
    task automatic rd(input logic [23:0] a, input logic [31:0] d, input int n);
        cmd(8'h10, a);
        sfl_host_i.xfer(8'hC3, r);
        for (int i = 0; i < n; i++) begin
            sfl_host_i.xfer(8'h69, r);
            check("read byte", r, d[31-8*i -: 8]);
        end
        sfl_host_i.frame_end();
    endtask

    // Cuts a hang short.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            wrap_up();
        end
    end

    // Main sequence.
    initial begin
        rst_n <= 1'b0;
        bp <= 5'h00;
        hw <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        cmd(8'h20, 24'h001000);
        sfl_host_i.xfer(8'h00, r);
        sfl_host_i.frame_end();
        repeat (20) @(posedge mclk);
        check("busy unarmed", {7'h00, busy}, 8'h00);
        done("unarmed");
        erase(24'h0010AB, 1'b0);
        erase(24'h07F123, 1'b1);
        erase(24'h000FFF, 1'b0);
        done("erase");
        prog(24'hF010FE, 32'hA53C0F00, 3);
        rd(24'h0010FD, 32'hFFA53CFF, 4);
        rd(24'hE01000, 32'h0FFF0000, 2);
        done("program");
        prog(24'h0010FE, 32'h0F000000, 1);
        rd(24'h0010FE, 32'h053C0000, 2);
        prog(24'h000000, 32'h12000000, 1);
        rd(24'h07FFFF, 32'hFF120000, 2);
        erase(24'h000123, 1'b0);
        rd(24'h000000, 32'hFFFF0000, 2);
        done("read");
        bp <= 5'h04;
        hw <= 1'b1;
        write_enable_cmd();
        cmd(8'h30, 24'h001000);
        sfl_host_i.frame_end();
        repeat (20) @(posedge mclk);
        check("busy locked", {7'h00, busy}, 8'h00);
        poll(1'b0, 8'h92);
        rd(24'h001000, 32'h0FFF0000, 2);
        done("protect");
        wrap_up();
    end
endmodule
